// *** simseq_ctrl.sv ***
// partner: controller that issues the acknowledge command
`timescale 1ns/10ps
module simseq_ctrl (
   // clock, reset, bench request
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ack_req,
   // wiring fault seen by the controlling system
   input wire logic wiring_fault,
   // command toward the device and supply switch
   output logic error_acknowledge_command,
   output logic supply_off
);
   logic deact;
   // a wiring fault first stops all commands, then the supply is switched off
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         deact <= 1'b0;
         supply_off <= 1'b0;
      end else begin
         deact <= deact | wiring_fault;
         supply_off <= supply_off | deact;
      end
   end
   // a pulse on every other cycle while ack_req is held; a held level would look like repeated commands
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         error_acknowledge_command <= 1'b0;
      end else begin
         error_acknowledge_command <= ack_req && !error_acknowledge_command && !deact;
      end
   end
endmodule

// *** simseq_pkg.sv ***
// package: modes, self test and error structures and timing constants of the input mode sequencer
package simseq_pkg;
   localparam int unsigned CLK_HZ = 50000000;
   // slow blink half period in ms, fast blink half period in ms
   localparam int unsigned SLOW_HALF_MS = 500;
   localparam int unsigned FAST_HALF_MS = 100;
   localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_MS * (CLK_HZ / 1000);
   localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * (CLK_HZ / 1000);
   // cycles spent checking configuration before operation
   localparam int unsigned CHECK_CYC = 16;
   localparam int unsigned BLINK_W = 25;

   typedef enum logic [2:0] {
      SIMSEQ_SELF_TEST,
      SIMSEQ_SERVICE,
      SIMSEQ_CHECK_CFG,
      SIMSEQ_OPERATIONAL,
      SIMSEQ_ERROR
   } simseq_mode_e;

   // self test outcome from the test engine
   typedef struct packed {
      logic done;
      logic cfg_present;
      logic fault;
   } simseq_test_s;

   // error sources while running
   typedef struct packed {
      logic internal;
      logic remote;
      logic serious;
   } simseq_err_s;
endpackage

// *** simseq_props.sv ***
// checker: mode sequencing and indicator assertions
`timescale 1ns/10ps
module simseq_props (
   // watched ports
   input wire logic mclk,
   input wire logic resetn,
   input wire simseq_pkg::simseq_test_s self_test,
   input wire simseq_pkg::simseq_err_s error_in,
   input wire logic cfg_check_ok,
   input wire logic error_acknowledge_command,
   input wire logic status_indicator,
   input wire logic error_indicator,
   input wire logic run_indicator,
   input wire simseq_pkg::simseq_mode_e mode
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   // mode and error decodes, shared by several properties
   wire tst = mode == simseq_pkg::SIMSEQ_SELF_TEST;
   wire erm = mode == simseq_pkg::SIMSEQ_ERROR;
   wire err = |error_in;
   AST_WAIT_TEST: assert property (tst && !self_test.done && !self_test.fault
      |=> tst) else $error("left test early");
   AST_TO_SERVICE: assert property (tst && self_test == 3'h4
      |=> mode == simseq_pkg::SIMSEQ_SERVICE && status_indicator) else $error("no service entry");
   AST_SERVICE_HOLD: assert property (mode == simseq_pkg::SIMSEQ_SERVICE
      |=> mode == simseq_pkg::SIMSEQ_SERVICE && status_indicator) else $error("service left");
   AST_TO_CHECK: assert property (tst && self_test == 3'h6
      |=> mode == simseq_pkg::SIMSEQ_CHECK_CFG) else $error("no check");
   AST_CHECK_BAD: assert property (mode == simseq_pkg::SIMSEQ_CHECK_CFG && !cfg_check_ok
      |=> mode != simseq_pkg::SIMSEQ_OPERATIONAL) else $error("bad config accepted");
   AST_TEST_FAULT: assert property (tst && self_test.fault
      |=> erm ##0 error_indicator) else $error("test fault missed");
   AST_OP_FAULT: assert property (mode == simseq_pkg::SIMSEQ_OPERATIONAL && err
      |=> erm) else $error("run fault missed");
   AST_OP_LEDS: assert property (mode == simseq_pkg::SIMSEQ_OPERATIONAL
      |-> run_indicator && !status_indicator) else $error("run leds wrong");
   AST_ERR_LED_OFF: assert property (!erm |-> !error_indicator) else $error("error led outside error");
   AST_ACK_HOLD: assert property (erm && err |=> erm) else $error("error left while present");
   AST_ACK_CLEAN: assert property (erm && error_acknowledge_command && !err
      |=> mode == simseq_pkg::SIMSEQ_CHECK_CFG) else $error("ack not via check");
   // main scenarios reached
   COV_SERVICE: cover property (mode == simseq_pkg::SIMSEQ_SERVICE);
   COV_RUN: cover property (mode == simseq_pkg::SIMSEQ_OPERATIONAL);
   COV_ACK: cover property (erm && error_acknowledge_command && !err);
   COV_CHECK_WAIT: cover property (mode == simseq_pkg::SIMSEQ_CHECK_CFG && !cfg_check_ok);
endmodule

// *** simseq_top.sv ***
// top: mode sequencer with status, run and error indicators
`timescale 1ns/10ps
module simseq_top #(
   parameter int unsigned SLOW_CYC = simseq_pkg::SLOW_HALF_CYC,
   parameter int unsigned FAST_CYC = simseq_pkg::FAST_HALF_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // self test result, error inputs and configuration check result
   input wire simseq_pkg::simseq_test_s self_test,
   input wire simseq_pkg::simseq_err_s error_in,
   input wire logic cfg_check_ok,
   // error_acknowledge_command, one cycle pulse
   input wire logic error_acknowledge_command,
   // indicators and mode
   output logic status_indicator,
   output logic error_indicator,
   output logic run_indicator,
   output simseq_pkg::simseq_mode_e mode
);
   simseq_pkg::simseq_mode_e next_mode;
   logic [7:0] check_cnt;
   logic [simseq_pkg::BLINK_W-1:0] slow_cnt;
   logic [simseq_pkg::BLINK_W-1:0] fast_cnt;
   logic slow_ph;
   logic fast_ph;
   logic any_err;
   logic serious;
   // acknowledge that may really leave error mode
   logic ack_clean;

   // any error source counts; the serious bit also feeds the blink latch
   assign any_err = error_in.internal | error_in.remote | error_in.serious;

   // an acknowledge only counts in error mode with every error source quiet;
   // the mode register and the serious latch must agree on it, so it is decoded once
   function automatic logic clean_ack(
      input simseq_pkg::simseq_mode_e cur_mode,
      input logic ack,
      input logic err
   );
      return (cur_mode == simseq_pkg::SIMSEQ_ERROR) && ack && !err;
   endfunction

   // true on the last count of a blink half period
   function automatic logic blink_wrap(
      input logic [simseq_pkg::BLINK_W-1:0] cnt,
      input int unsigned half_cyc
   );
      return cnt == simseq_pkg::BLINK_W'(half_cyc - 1);
   endfunction

   // counter advance held at the counter width, so a carry out of the top bit is dropped
   function automatic logic [simseq_pkg::BLINK_W-1:0] blink_next(
      input logic [simseq_pkg::BLINK_W-1:0] cnt
   );
      return cnt + simseq_pkg::BLINK_W'(1);
   endfunction

   // status pattern for the mode about to be entered
   function automatic logic status_level(
      input simseq_pkg::simseq_mode_e nm,
      input logic slow
   );
      logic lvl;
      lvl = 1'b0;
      case (nm)
         simseq_pkg::SIMSEQ_SERVICE: lvl = 1'b1;
         simseq_pkg::SIMSEQ_CHECK_CFG: lvl = slow;
         default: lvl = 1'b0; // off in operation
      endcase
      return lvl;
   endfunction

   // error pattern: steady for an ordinary error, fast blink while a serious error is known
   function automatic logic error_level(
      input simseq_pkg::simseq_mode_e nm,
      input logic grave,
      input logic fast
   );
      logic lvl;
      lvl = 1'b0;
      if (nm == simseq_pkg::SIMSEQ_ERROR) begin
         lvl = grave ? fast : 1'b1;
      end
      return lvl;
   endfunction

   // one decode of the clean acknowledge, shared by the mode and the serious latch
   assign ack_clean = clean_ack(mode, error_acknowledge_command, any_err);

   // mode transitions
   // every path out of self test is chosen by the test result alone
   // only the check branch also waits on its dwell counter; every other branch moves on the very edge that sees its cause
   always_comb begin
      next_mode = mode;
      case (mode)
         simseq_pkg::SIMSEQ_SELF_TEST: begin
            if (self_test.fault) begin
               next_mode = simseq_pkg::SIMSEQ_ERROR;
            end else if (self_test.done) begin
               // the test alone picks the path
               next_mode = self_test.cfg_present ? simseq_pkg::SIMSEQ_CHECK_CFG
                                                 : simseq_pkg::SIMSEQ_SERVICE;
            end
         end
         // only a restart leaves service; an acknowledge here is ignored
         simseq_pkg::SIMSEQ_SERVICE: next_mode = simseq_pkg::SIMSEQ_SERVICE;
         simseq_pkg::SIMSEQ_CHECK_CFG: begin
            // an error while checking is handled like one in operation
            if (any_err) begin
               next_mode = simseq_pkg::SIMSEQ_ERROR;
            end else if (cfg_check_ok && check_cnt == 8'(simseq_pkg::CHECK_CYC - 1)) begin
               next_mode = simseq_pkg::SIMSEQ_OPERATIONAL;
            end
         end
         simseq_pkg::SIMSEQ_OPERATIONAL: begin
            if (any_err) begin
               next_mode = simseq_pkg::SIMSEQ_ERROR;
            end
         end
         simseq_pkg::SIMSEQ_ERROR: begin
            // persisting error keeps error mode; clean exit re-checks
            if (ack_clean) begin
               next_mode = simseq_pkg::SIMSEQ_CHECK_CFG;
            end
         end
         default: next_mode = simseq_pkg::SIMSEQ_SELF_TEST;
      endcase
   end

   // mode register, restart always begins in self test
   // asynchronous reset, so a restart reaches self test even before the clock runs
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mode <= simseq_pkg::SIMSEQ_SELF_TEST;
      end else begin
         mode <= next_mode;
      end
   end

   // short check dwell so the slow blink is normally not seen
   // the counter saturates, so a late cfg_check_ok moves on at the very next edge
   // limitation: a check that never passes leaves the module in this mode
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         check_cnt <= 8'h00;
      end else if (mode != simseq_pkg::SIMSEQ_CHECK_CFG) begin
         check_cnt <= 8'h00;
      end else if (check_cnt != 8'(simseq_pkg::CHECK_CYC - 1)) begin
         check_cnt <= check_cnt + 8'h01;
      end
   end

   // serious error latch, cleared only by a clean acknowledge
   // it keeps the fast blink after the serious input drops, until the controller acknowledges
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         serious <= 1'b0;
      end else if (error_in.serious) begin
         serious <= 1'b1; // set wins over clear
      end else if (ack_clean) begin
         serious <= 1'b0;
      end
   end

   // free running blink dividers shared by every mode
   // a blink seen right after a mode change may have a short first half period;
   // accepted, since a private divider per mode would cost more counters for a cosmetic gain
   // both dividers restart on reset, so their phase is known after every restart
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         slow_cnt <= '0;
         slow_ph <= 1'b0;
      end else if (blink_wrap(slow_cnt, SLOW_CYC)) begin
         slow_cnt <= '0;
         slow_ph <= ~slow_ph;
      end else begin
         slow_cnt <= blink_next(slow_cnt);
      end
   end

   // fast divider for the serious error blink
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         fast_cnt <= '0;
         fast_ph <= 1'b0;
      end else if (blink_wrap(fast_cnt, FAST_CYC)) begin
         fast_cnt <= '0;
         fast_ph <= ~fast_ph;
      end else begin
         fast_cnt <= blink_next(fast_cnt);
      end
   end

   // status indicator registered from the next mode so it lines up with the mode register
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         status_indicator <= 1'b0;
      end else begin
         status_indicator <= status_level(next_mode, slow_ph);
      end
   end

   // error indicator; the live serious input is folded in so the first error cycle already blinks
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         error_indicator <= 1'b0;
      end else begin
         error_indicator <= error_level(next_mode, serious | error_in.serious, fast_ph);
      end
   end

   // run indicator, lit only in unlimited operation
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         run_indicator <= 1'b0;
      end else begin
         run_indicator <= (next_mode == simseq_pkg::SIMSEQ_OPERATIONAL);
      end
   end
endmodule

// *** tb_top.sv ***
// testbench: restart paths, error entry and acknowledge
`timescale 1ns/10ps
module tb_top;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic ack_req = 1'b0;
   logic cfg_check_ok = 1'b1;
   logic wiring_fault = 1'b0;
   simseq_pkg::simseq_test_s self_test = '0;
   simseq_pkg::simseq_err_s error_in = '0;
   logic status_indicator, error_indicator, run_indicator, ack, s, supply_off;
   simseq_pkg::simseq_mode_e mode;
   int errors = 0;
   int n_compared = 0;
   initial forever #10 mclk = ~mclk;
   simseq_ctrl PARTNER (.mclk(mclk), .resetn(resetn), .ack_req(ack_req), .wiring_fault(wiring_fault),
      .error_acknowledge_command(ack), .supply_off(supply_off));
   simseq_top #(.SLOW_CYC(4), .FAST_CYC(2)) DUT (.mclk(mclk), .resetn(resetn), .self_test(self_test),
      .error_in(error_in), .cfg_check_ok(cfg_check_ok), .error_acknowledge_command(ack),
      .status_indicator(status_indicator), .error_indicator(error_indicator),
      .run_indicator(run_indicator), .mode(mode));
   // inputs move 1 ns after each edge
   task step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task chk(input logic [2:0] got, input logic [2:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task print_verdict;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task wait_mode(input simseq_pkg::simseq_mode_e m);
      for (int i = 0; i < 40 && mode !== m; i++)
         step(1);
      chk(mode, m);
      if (mode !== m)
         print_verdict();
   endtask
   task restart(input logic [2:0] t);
      resetn = 1'b0;
      self_test = t;
      error_in = '0;
      wiring_fault = 1'b0;
      cfg_check_ok = 1'b1;
      step(5);
      resetn = 1'b1;
   endtask
   task ack_pulse;
      ack_req = 1'b1;
      step(1);
      ack_req = 1'b0;
      step(2);
   endtask
   // empty store: service is final, ack refused
   task t_service;
      restart(3'h0);
      step(3);
      chk(mode, simseq_pkg::SIMSEQ_SELF_TEST);
      self_test = 3'h4;
      step(1);
      chk(mode, simseq_pkg::SIMSEQ_SERVICE);
      chk(status_indicator, 1'b1);
      ack_pulse();
      chk(mode, simseq_pkg::SIMSEQ_SERVICE);
   endtask
   // stored config: check, run, error, acks
   task t_run;
      restart(3'h6);
      step(1);
      chk(mode, simseq_pkg::SIMSEQ_CHECK_CFG);
      s = status_indicator;
      step(4);
      chk(status_indicator, !s);
      wait_mode(simseq_pkg::SIMSEQ_OPERATIONAL);
      chk({run_indicator, status_indicator}, 3'h2);
      error_in = 3'h4;
      step(1);
      chk({mode == simseq_pkg::SIMSEQ_ERROR, error_indicator}, 3'h3);
      ack_pulse();
      chk(mode, simseq_pkg::SIMSEQ_ERROR);
      error_in = 3'h0;
      ack_pulse();
      chk(mode, simseq_pkg::SIMSEQ_CHECK_CFG);
      cfg_check_ok = 1'b0;
      step(20);
      chk(mode, simseq_pkg::SIMSEQ_CHECK_CFG);
      cfg_check_ok = 1'b1;
      wait_mode(simseq_pkg::SIMSEQ_OPERATIONAL);
      error_in = 3'h1;
      step(1);
      s = error_indicator;
      step(2);
      chk(error_indicator, !s);
   endtask
   // self test fault goes straight to error mode with a steady error indicator
   task t_test_fault;
      restart(3'h5);
      step(1);
      chk(mode, simseq_pkg::SIMSEQ_ERROR);
      chk(error_indicator, 1'b1);
   endtask
   // wiring fault: the controller withholds commands and switches the supply off
   task t_wiring;
      restart(3'h6);
      wait_mode(simseq_pkg::SIMSEQ_OPERATIONAL);
      wiring_fault = 1'b1;
      error_in = 3'h4;
      step(1);
      chk(mode, simseq_pkg::SIMSEQ_ERROR);
      error_in = 3'h0;
      ack_pulse();
      chk(mode, simseq_pkg::SIMSEQ_ERROR);
      chk(supply_off, 1'b1);
   endtask
   initial begin
      t_service();
      t_run();
      t_test_fault();
      t_wiring();
      print_verdict();
   end
endmodule
bind simseq_top simseq_props CHK (.mclk(mclk), .resetn(resetn), .self_test(self_test), .error_in(error_in),
   .cfg_check_ok(cfg_check_ok), .error_acknowledge_command(error_acknowledge_command),
   .status_indicator(status_indicator), .error_indicator(error_indicator), .run_indicator(run_indicator), .mode(mode));
